// [hdl/channel_calibration_registers.sv]
// Channel 6/7 calibration and configuration register bank with channel 7 correction path
//
// Notes on behaviour
// - Gain is 24 bits: high register holds 23..8, low register upper byte 7..0.
// - Gain is unsigned, from zero up to just under two.
// - Gain high resets to 8000h, low to 0000h; channel 6 at 2Ah/2Bh.
// - Offset is 24-bit two's complement split like the gain.
// - Low byte of every low calibration register reads zero, writes ignored.
// - Config bits 15..6 hold a signed 10-bit phase delay in modulator clocks.
// - Config bits 5..3 are read-only zero.
// - Config bit 2 set bypasses the DC filter for this channel, else global.
// - Config bits 1..0 choose pins, shorted, positive or negative test signal.
// - Channel 7 config sits at 2Ch and resets to zero.
// - Channel 7 offset high 2Dh, offset low 2Eh, gain high 2Fh; offsets reset zero.
`timescale 1ns/1ps
module channel_calibration_registers
   import chcal_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 24
) (
   // Clock, reset, enable
   input  wire logic              i_core_clk,
   input  wire logic              i_rst_n,
   input  wire logic              i_ce,
   // Register port
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [15:0]       i_wdata,
   input  wire logic              i_wr,
   input  wire logic              i_rd,
   output logic [15:0]            o_rdata,
   // Channel 6 gain term
   output logic [DATA_W-1:0]      o_ch6_gain,
   // Channel 7 controls
   output logic [DATA_W-1:0]      o_ch7_gain,
   output logic [DATA_W-1:0]      o_ch7_offset,
   output logic [9:0]             o_ch7_phase_delay,
   output logic [1:0]             o_ch7_input_select,
   output logic                   o_ch7_select_pins,
   output logic                   o_ch7_select_shorted,
   output logic                   o_ch7_select_test_pos,
   output logic                   o_ch7_select_test_neg,
   // DC filter steering
   input  wire logic              i_global_dc_filter_setting,
   output logic                   o_ch7_dc_filter_enable,
   // Channel 7 sample path
   input  wire logic              i_ch7_raw_valid,
   input  wire logic [DATA_W-1:0] i_ch7_raw_sample,
   output logic                   o_ch7_corr_valid,
   output logic [DATA_W-1:0]      o_ch7_corr_sample
);
   initial begin
      if (ADDR_W < 8 || DATA_W != 24) begin
         $error("channel_calibration_registers: ADDR_W must be >= 8 and DATA_W 24");
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register storage

   localparam int NREG = 7;
   localparam logic [7:0] REG_ADDR [NREG] = '{
      ADDR_CH6_GAIN_CAL_HIGH, ADDR_CH6_GAIN_CAL_LOW, ADDR_CH7_CONFIG,
      ADDR_CH7_OFFSET_CAL_HIGH, ADDR_CH7_OFFSET_CAL_LOW, ADDR_CH7_GAIN_CAL_HIGH,
      ADDR_CH7_GAIN_CAL_LOW};
   localparam logic [15:0] REG_RST [NREG] = '{
      RST_GAIN_HIGH, RST_GAIN_LOW, RST_CONFIG,
      RST_OFFSET_HIGH, RST_OFFSET_LOW, RST_GAIN_HIGH, RST_GAIN_LOW};
   // Low registers and config keep reserved bits at zero through the write mask
   localparam logic [15:0] REG_MASK [NREG] = '{
      MASK_FULL, MASK_LOW, MASK_CONFIG,
      MASK_FULL, MASK_LOW, MASK_FULL, MASK_LOW};

   localparam int IX_CH6_GH = 0;
   localparam int IX_CH6_GL = 1;
   localparam int IX_CH7_CF = 2;
   localparam int IX_CH7_OH = 3;
   localparam int IX_CH7_OL = 4;
   localparam int IX_CH7_GH = 5;
   localparam int IX_CH7_GL = 6;

   logic [15:0] regs_ff [NREG];

   // Address hit for one register; shared by write and read decoding
   function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [7:0] reg_addr);
      return addr == ADDR_W'(reg_addr);
   endfunction

   generate
      for (genvar g = 0; g < NREG; g++) begin : g_reg
         always_ff @(posedge i_core_clk) begin
            if (!i_rst_n) begin
               regs_ff[g] <= REG_RST[g];
            end else if (i_ce && i_wr && addr_hit(i_addr, REG_ADDR[g])) begin
               regs_ff[g] <= i_wdata & REG_MASK[g];
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // Read path: data one cycle after the strobe, unmapped reads return zero

   logic [15:0] nxt_rdata;
   logic [15:0] rdata_ff;

   always_comb begin
      nxt_rdata = 16'h0000;
      for (int i = 0; i < NREG; i++) begin
         if (addr_hit(i_addr, REG_ADDR[i])) begin
            nxt_rdata = regs_ff[i] & REG_MASK[i];
         end
      end
      if (addr_hit(i_addr, ADDR_CH7_SAMPLE_HIGH)) begin
         nxt_rdata = o_ch7_corr_sample[DATA_W-1:8];
      end else if (addr_hit(i_addr, ADDR_CH7_SAMPLE_LOW)) begin
         nxt_rdata = {o_ch7_corr_sample[7:0], 8'h00};
      end
   end

   // Read data stands only in the cycle after the read strobe
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         rdata_ff <= 16'h0000;
      end else if (i_ce) begin
         rdata_ff <= i_rd ? nxt_rdata : 16'h0000;
      end
   end

   assign o_rdata = rdata_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Field extraction

   input_select_e ch7_sel;

   always_comb begin
      o_ch6_gain   = {regs_ff[IX_CH6_GH], regs_ff[IX_CH6_GL][LOW_BYTE_MSB:LOW_BYTE_LSB]};
      o_ch7_gain   = {regs_ff[IX_CH7_GH], regs_ff[IX_CH7_GL][LOW_BYTE_MSB:LOW_BYTE_LSB]};
      o_ch7_offset = {regs_ff[IX_CH7_OH], regs_ff[IX_CH7_OL][LOW_BYTE_MSB:LOW_BYTE_LSB]};
      o_ch7_phase_delay  = regs_ff[IX_CH7_CF][PHASE_MSB:PHASE_LSB];
      o_ch7_input_select = regs_ff[IX_CH7_CF][INSEL_MSB:INSEL_LSB];
      ch7_sel = input_select_e'(o_ch7_input_select);
      o_ch7_select_pins     = 1'b0;
      o_ch7_select_shorted  = 1'b0;
      o_ch7_select_test_pos = 1'b0;
      o_ch7_select_test_neg = 1'b0;
      unique case (ch7_sel)
         INSEL_PINS:     o_ch7_select_pins     = 1'b1;
         INSEL_SHORTED:  o_ch7_select_shorted  = 1'b1;
         INSEL_TEST_POS: o_ch7_select_test_pos = 1'b1;
         INSEL_TEST_NEG: o_ch7_select_test_neg = 1'b1;
      endcase
      // Bypass bit overrides the global setting for this channel only
      o_ch7_dc_filter_enable = i_global_dc_filter_setting
                               && !regs_ff[IX_CH7_CF][DC_BYPASS_BIT];
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Channel 7 correction; the raw sample is same-clock logic, so no synchroniser

   gain_offset_corrector #(
      .DATA_W (DATA_W)
   ) u_corr (
      .i_core_clk (i_core_clk),
      .i_rst_n    (i_rst_n),
      .i_ce       (i_ce),
      .i_offset   (o_ch7_offset),
      .i_gain     (o_ch7_gain),
      .i_valid    (i_ch7_raw_valid),
      .i_sample   (i_ch7_raw_sample),
      .o_valid    (o_ch7_corr_valid),
      .o_sample   (o_ch7_corr_sample)
   );
endmodule

// [hdl/chcal_pkg.sv]
// Package: register map, field layout and reset values of the channel calibration bank
package chcal_pkg;
   // Register addresses (register index on the 8-bit address port)
   localparam logic [7:0] ADDR_CH6_GAIN_CAL_HIGH   = 8'h2a;
   localparam logic [7:0] ADDR_CH6_GAIN_CAL_LOW    = 8'h2b;
   localparam logic [7:0] ADDR_CH7_CONFIG          = 8'h2c;
   localparam logic [7:0] ADDR_CH7_OFFSET_CAL_HIGH = 8'h2d;
   localparam logic [7:0] ADDR_CH7_OFFSET_CAL_LOW  = 8'h2e;
   localparam logic [7:0] ADDR_CH7_GAIN_CAL_HIGH   = 8'h2f;
   // Register addresses of channel 7 gain low (next to this bank) and a local sample port
   localparam logic [7:0] ADDR_CH7_GAIN_CAL_LOW    = 8'h30;
   localparam logic [7:0] ADDR_CH7_SAMPLE_HIGH     = 8'h40;
   localparam logic [7:0] ADDR_CH7_SAMPLE_LOW      = 8'h41;

   // Reset values
   localparam logic [15:0] RST_GAIN_HIGH   = 16'h8000;
   localparam logic [15:0] RST_GAIN_LOW    = 16'h0000;
   localparam logic [15:0] RST_OFFSET_HIGH = 16'h0000;
   localparam logic [15:0] RST_OFFSET_LOW  = 16'h0000;
   localparam logic [15:0] RST_CONFIG      = 16'h0000;

   // Field positions
   localparam int LOW_BYTE_MSB   = 15;
   localparam int LOW_BYTE_LSB   = 8;
   localparam int PHASE_MSB      = 15;
   localparam int PHASE_LSB      = 6;
   localparam int DC_BYPASS_BIT  = 2;
   localparam int INSEL_MSB      = 1;
   localparam int INSEL_LSB      = 0;

   // Writable bits of each register
   localparam logic [15:0] MASK_FULL   = 16'hffff;
   localparam logic [15:0] MASK_LOW    = 16'hff00;
   localparam logic [15:0] MASK_CONFIG = 16'hffc7;

   // Gain has one integer bit: 0x800000 is unity
   localparam int GAIN_FRAC_BITS = 23;

   typedef enum logic [1:0] {
      INSEL_PINS,
      INSEL_SHORTED,
      INSEL_TEST_POS,
      INSEL_TEST_NEG
   } input_select_e;
endpackage

// [hdl/gain_offset_corrector.sv]
// Corrector: subtracts offset then scales by the unsigned 1.23 gain, one sample per cycle
`timescale 1ns/1ps
module gain_offset_corrector
   import chcal_pkg::*;
#(
   parameter int DATA_W = 24
) (
   // Clock and control
   input  wire logic              i_core_clk,
   input  wire logic              i_rst_n,
   input  wire logic              i_ce,
   // Correction terms
   input  wire logic [DATA_W-1:0] i_offset,
   input  wire logic [DATA_W-1:0] i_gain,
   // Sample stream
   input  wire logic              i_valid,
   input  wire logic [DATA_W-1:0] i_sample,
   output logic                   o_valid,
   output logic [DATA_W-1:0]      o_sample
);
   localparam int DIFF_W = DATA_W + 1;
   localparam int PROD_W = DIFF_W + DATA_W + 1;
   localparam logic signed [PROD_W-1:0] MAX_OUT = PROD_W'((1 <<< (DATA_W - 1)) - 1);
   localparam logic signed [PROD_W-1:0] MIN_OUT = -PROD_W'(1 <<< (DATA_W - 1));

   initial begin
      if (DATA_W < 2 || DATA_W > 30) begin
         $error("gain_offset_corrector: DATA_W out of range");
      end
   end

   logic signed [DIFF_W-1:0] diff;
   logic signed [PROD_W-1:0] product;
   logic signed [PROD_W-1:0] scaled;
   logic [DATA_W-1:0]        nxt_sample;

   always_comb begin
      diff    = DIFF_W'(signed'(i_sample)) - DIFF_W'(signed'(i_offset));
      product = PROD_W'(diff) * PROD_W'(signed'({1'b0, i_gain}));
      scaled  = product >>> GAIN_FRAC_BITS;
      // Saturate rather than wrap so a large gain cannot flip the sign
      if (scaled > MAX_OUT) begin
         nxt_sample = MAX_OUT[DATA_W-1:0];
      end else if (scaled < MIN_OUT) begin
         nxt_sample = MIN_OUT[DATA_W-1:0];
      end else begin
         nxt_sample = scaled[DATA_W-1:0];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_valid  <= 1'b0;
         o_sample <= '0;
      end else if (i_ce) begin
         o_valid  <= i_valid;
         if (i_valid) begin
            o_sample <= nxt_sample;
         end
      end
   end
endmodule

// [tb/channel_calibration_registers_tb.sv]
// Testbench: register access, field decode and correction path of the bank
`timescale 1ns/1ps
module channel_calibration_registers_tb
   import chcal_pkg::*;
;
   logic        i_core_clk = 0, i_rst_n = 0, i_ce = 1, i_wr = 0, i_rd = 0, i_glob = 1, i_rv = 0;
   logic [7:0]  i_addr = 0;
   logic [15:0] i_wdata = 0, o_rdata;
   logic [23:0] i_raw = 0, o_g6, o_g7, o_off, o_cs;
   logic [9:0]  o_ph;
   logic [1:0]  o_sel;
   logic        o_pins, o_short, o_pos, o_neg, o_dc, o_cv;
   int          miscompares = 0, checks = 0;
   always #12.5 i_core_clk = ~i_core_clk;
   channel_calibration_registers dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
      .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
      .o_ch6_gain(o_g6), .o_ch7_gain(o_g7), .o_ch7_offset(o_off), .o_ch7_phase_delay(o_ph),
      .o_ch7_input_select(o_sel), .o_ch7_select_pins(o_pins), .o_ch7_select_shorted(o_short),
      .o_ch7_select_test_pos(o_pos), .o_ch7_select_test_neg(o_neg),
      .i_global_dc_filter_setting(i_glob), .o_ch7_dc_filter_enable(o_dc),
      .i_ch7_raw_valid(i_rv), .i_ch7_raw_sample(i_raw), .o_ch7_corr_valid(o_cv),
      .o_ch7_corr_sample(o_cs));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_core_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] a, input logic [15:0] exp);
      @(posedge i_core_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      #1;
      chk({8'h00, o_rdata}, {8'h00, exp});
   endtask
   // One raw sample through the correction path, judged while valid stands
   task automatic smp(input logic [23:0] raw, input logic [23:0] exp);
      @(posedge i_core_clk);
      i_rv <= 1'b1;
      i_raw <= raw;
      @(posedge i_core_clk);
      i_rv <= 1'b0;
      #1;
      chk({23'h0, o_cv}, 24'h1);
      chk(o_cs, exp);
   endtask
   task automatic give_verdict();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_values();
      rd(8'h2a, 16'h8000);
      rd(8'h2b, 16'h0000);
      rd(8'h2c, 16'h0000);
      rd(8'h2d, 16'h0000);
      rd(8'h2e, 16'h0000);
      rd(8'h2f, 16'h8000);
      chk(o_g6, 24'h800000);
      chk({23'h0, o_pins}, 24'h1);
   endtask
   // All ones exposes any reserved bit of 2Ah to 2Fh that wrongly latches
   task automatic t_masks();
      logic [7:0]  a[6] = '{8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f};
      logic [15:0] e[6] = '{16'hffff, 16'hff00, 16'hffc7, 16'hffff, 16'hff00, 16'hffff};
      foreach (a[i]) begin
         wr(a[i], 16'hffff);
         rd(a[i], e[i]);
      end
      wr(8'h3c, 16'h1234);
      rd(8'h3c, 16'h0000);
      chk(o_g6, 24'hffffff);
      chk(o_off, 24'hffffff);
   endtask
   task automatic t_config();
      logic [15:0] d;
      for (int m = 0; m < 4; m++) begin
         d = {10'h201 + 10'(m), 3'b111, m[0], 2'(m)};
         wr(8'h2c, d);
         chk({14'h0, o_ph}, {14'h0, d[15:6]});
         chk({22'h0, o_sel}, 24'(m));
         chk({20'h0, o_neg, o_pos, o_short, o_pins}, 24'h1 << m);
         chk({23'h0, o_dc}, {23'h0, !m[0]});
         rd(8'h2c, d & 16'hffc7);
      end
      // Bypass clear: the global setting alone decides
      wr(8'h2c, 16'h0000);
      @(posedge i_core_clk);
      i_glob <= 1'b0;
      @(posedge i_core_clk);
      #1;
      chk({23'h0, o_dc}, 24'h0);
      @(posedge i_core_clk);
      i_glob <= 1'b1;
      @(posedge i_core_clk);
      #1;
      chk({23'h0, o_dc}, 24'h1);
   endtask
   // Gains either side of unity, offset 10h removed first
   task automatic t_correction();
      logic [15:0] g[2] = '{16'h4000, 16'hc000};
      logic [23:0] e[2] = '{24'h000100, 24'h000300};
      wr(8'h2d, 16'h0000);
      wr(8'h2e, 16'h1000);
      wr(8'h30, 16'h0000);
      foreach (g[i]) begin
         wr(8'h2f, g[i]);
         chk(o_g7, {g[i], 8'h00});
         smp(24'h000210, e[i]);
      end
      // Offset of minus one: 211h times 1.5 floors to 319h
      wr(8'h2d, 16'hffff);
      wr(8'h2e, 16'hffff);
      chk(o_off, 24'hffffff);
      smp(24'h000210, 24'h000319);
      rd(8'h40, 16'h0003);
      rd(8'h41, 16'h1900);
   endtask
   // A write with the enable low must not land
   task automatic t_ce_freeze();
      @(posedge i_core_clk);
      i_ce <= 1'b0;
      i_wr <= 1'b1;
      i_addr <= 8'h2d;
      i_wdata <= 16'h1234;
      @(posedge i_core_clk);
      i_ce <= 1'b1;
      i_wr <= 1'b0;
      #1;
      rd(8'h2d, 16'hffff);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
      t_reset_values();
      t_masks();
      t_config();
      t_correction();
      t_ce_freeze();
      give_verdict();
   end
   initial begin
      #100000;
      miscompares++;
      give_verdict();
   end
endmodule
bind channel_calibration_registers chcal_monitor mon (.i_core_clk(i_core_clk),
   .i_rst_n(i_rst_n), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
   .i_rd(i_rd), .o_rdata(o_rdata), .o_ch7_gain(o_ch7_gain), .o_ch7_offset(o_ch7_offset),
   .o_ch7_phase_delay(o_ch7_phase_delay), .o_ch7_input_select(o_ch7_input_select),
   .o_ch7_select_pins(o_ch7_select_pins), .o_ch7_select_shorted(o_ch7_select_shorted),
   .o_ch7_select_test_pos(o_ch7_select_test_pos), .o_ch7_select_test_neg(o_ch7_select_test_neg),
   .i_global_dc_filter_setting(i_global_dc_filter_setting),
   .o_ch7_dc_filter_enable(o_ch7_dc_filter_enable), .i_ch7_raw_valid(i_ch7_raw_valid),
   .o_ch7_corr_valid(o_ch7_corr_valid));

// [tb/chcal_monitor.sv]
// Checker: port relations of the channel calibration register bank
`timescale 1ns/1ps
module chcal_monitor
   import chcal_pkg::*;
(
   // Clock and register port
   input wire logic        i_core_clk,
   input wire logic        i_rst_n,
   input wire logic        i_ce,
   input wire logic [7:0]  i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [15:0] o_rdata,
   // Channel 7 controls
   input wire logic [23:0] o_ch7_gain,
   input wire logic [23:0] o_ch7_offset,
   input wire logic [9:0]  o_ch7_phase_delay,
   input wire logic [1:0]  o_ch7_input_select,
   input wire logic        o_ch7_select_pins,
   input wire logic        o_ch7_select_shorted,
   input wire logic        o_ch7_select_test_pos,
   input wire logic        o_ch7_select_test_neg,
   input wire logic        i_global_dc_filter_setting,
   input wire logic        o_ch7_dc_filter_enable,
   // Sample path
   input wire logic        i_ch7_raw_valid,
   input wire logic        o_ch7_corr_valid
);
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   sequence s_wr(logic [7:0] a);
      i_ce && i_wr && i_addr == a;
   endsequence
   sequence s_rd(logic [7:0] a);
      i_ce && i_rd && i_addr == a;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   a_gain_reset: assert property ($rose(i_rst_n) |->
      o_ch7_gain == 24'h800000 && o_ch7_offset == 24'h000000)
      else $error("bad reset terms");
   a_rdata_idle: assert property (i_ce && !i_rd |=> o_rdata == 16'h0000)
      else $error("read data not zero");
   a_low_rsvd: assert property (s_rd(8'h2b) or s_rd(8'h2e) or s_rd(8'h30)
      |=> o_rdata[7:0] == 8'h00)
      else $error("reserved low byte");
   a_cfg_rsvd: assert property (s_rd(8'h2c) |=> o_rdata[5:3] == 3'h0)
      else $error("reserved config bits");
   a_phase_load: assert property (s_wr(8'h2c) |=> o_ch7_phase_delay == $past(i_wdata[15:6]))
      else $error("phase delay");
   a_dc_steer: assert property (s_wr(8'h2c) |=>
      o_ch7_dc_filter_enable == (i_global_dc_filter_setting && !$past(i_wdata[2])))
      else $error("dc filter steering");
   a_sel_onehot: assert property (
      {o_ch7_select_test_neg, o_ch7_select_test_pos, o_ch7_select_shorted, o_ch7_select_pins}
         == 4'h1 << o_ch7_input_select)
      else $error("input select decode");
   a_gain_high: assert property (s_wr(8'h2f) |=> o_ch7_gain[23:8] == $past(i_wdata))
      else $error("gain high field");
   a_offset_low: assert property (s_wr(8'h2e) |=> o_ch7_offset[7:0] == $past(i_wdata[15:8]))
      else $error("offset low field");
   a_corr_valid: assert property (i_ce && i_ch7_raw_valid |=> o_ch7_corr_valid)
      else $error("corrected sample missing");
endmodule
